// ---- hw/spasc_pkg.sv ----
// package for the serdes pcs ability/status/counter register bank
// assumes a single 20 MHz system clock and an axi4-lite register bus
package spasc_pkg;

	// -----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// -----------------------------------------------------------------
	localparam logic [4:0] IDX_ADV_CFG = 5'h19;
	localparam logic [4:0] IDX_LP_CFG = 5'h1A;
	localparam logic [4:0] IDX_ALIGN_STAT = 5'h1B;
	localparam logic [4:0] IDX_GOOD_CNT = 5'h1C;
	localparam logic [4:0] IDX_CRCERR_CNT = 5'h1D;
	localparam logic [4:0] IDX_CTRL = 5'h1E;
	localparam logic [4:0] IDX_IRQ_STAT = 5'h1F;
	localparam logic [4:0] IDX_IRQ_CLR = 5'h10;
	localparam logic [4:0] IDX_IRQ_EN = 5'h11;

	// -----------------------------------------------------------------
	// field positions and reset values
	// -----------------------------------------------------------------
	localparam int STAT_REALIGN = 15;
	localparam int STAT_SIGDET = 14;
	localparam int STAT_FEFI = 13;
	localparam int STAT_COMMA = 12;
	localparam int STAT_POS_LSB = 8;
	localparam int STAT_HLS = 7;
	localparam int GOOD_SINCE = 15;
	localparam int SEL_LSB = 14;
	localparam int CTRL_FORCE = 0;
	localparam logic [15:0] ADV_RESET = 16'h0000;
	localparam logic [13:0] GOOD_WRAP = 14'h2710; // ten thousand
	localparam logic [7:0] CRCERR_MAX = 8'hFF;
	localparam logic [1:0] SEL_MEDIA = 2'h0;
	localparam logic [1:0] SEL_MAC = 2'h1;
	localparam int IRQ_W = 5;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic realign;
		logic sig_det;
		logic fefi;
		logic comma;
		logic [3:0] comma_pos;
		logic hls;
		logic cfg_valid;
		logic [15:0] cfg_word;
	} spasc_pcs_ev_t;

	typedef struct packed {
		logic good;
		logic crc_err;
	} spasc_pkt_ev_t;

endpackage : spasc_pkg

// ---- hw/spasc_pkt_cnt.sv ----
// receive crc good / crc error counters for one serdes source
// assumes events are single-cycle pulses on the system clock
module spasc_pkt_cnt
	import spasc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// events and clears
	input wire logic link_up,
	input spasc_pkt_ev_t ev,
	input wire logic good_clr,
	input wire logic err_clr,
	// counts
	output logic good_since,
	output logic [13:0] good_cnt,
	output logic [7:0] err_cnt
);

	// -----------------------------------------------------------------
	// next values: clear first, event counted after the clear
	// -----------------------------------------------------------------
	logic good_ev;
	logic err_ev;
	logic [13:0] good_base;
	logic [13:0] good_inc;
	logic [7:0] err_base;
	assign good_ev = ev.good & link_up;
	assign err_ev = ev.crc_err & link_up;
	assign good_base = good_clr ? 14'h0000 : good_cnt;
	assign good_inc = (good_base + 14'h0001 == GOOD_WRAP) ? 14'h0000 : good_base + 14'h0001;
	assign err_base = err_clr ? 8'h00 : err_cnt;

	// counter registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			good_cnt <= 14'h0000;
			good_since <= 1'b0;
			err_cnt <= 8'h00;
		end else begin
			good_cnt <= good_ev ? good_inc : good_base;
			good_since <= good_ev | (good_since & ~good_clr);
			err_cnt <= (err_ev && err_base != CRCERR_MAX) ? err_base + 8'h01 : err_base;
		end
	end

	chk_good_wrap: assert property (@(posedge clk) disable iff (rst)
		good_cnt < GOOD_WRAP) else $error("good counter past wrap");
	chk_err_link: assert property (@(posedge clk) disable iff (rst)
		!link_up && !err_clr |=> err_cnt == $past(err_cnt))
		else $error("error counter moved with link down");

endmodule : spasc_pkt_cnt

// ---- hw/spasc_regs.sv ----
// serdes pcs ability, alignment status and receive counter register bank
// assumes axi4-lite master on CLK_SYS; pcs events are single-cycle pulses
// or levels already on CLK_SYS

// Summary of operation
// - advertised word writable only while forced
// - advertised read undefined unless forced
// - capture last received partner config word
// - bit 15 comma realign, clears on read
// - bit 14 sticky signal detect, clear on read
// - bit 13 far-end fault, held until read
// - bit 12 live comma, read sets one
// - bits 11:8 comma position zero to nine
// - bit 7 halt line-state, held until read
// - good bit 15 packet since last read
// - good count wraps at ten thousand
// - good counter clears on read
// - select field picks media or mac counters
// - error count saturates, clears on read
// - counters advance only with link up
// - forced word replaces automatic advertised word
module spasc_regs
	import spasc_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// axi4-lite write channels
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read channels
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// pcs side
	input spasc_pcs_ev_t PCS_EV,
	input wire logic [15:0] AUTO_ADV_WORD,
	input wire logic PROTO_XFER_MODE,
	input wire logic MEDIA_LINK_UP,
	input spasc_pkt_ev_t MEDIA_PKT,
	input spasc_pkt_ev_t MAC_PKT,
	// outputs
	output logic [15:0] ADV_WORD_OUT,
	output logic IRQ
);

	// -----------------------------------------------------------------
	// write channel: both halves latched in any order
	// -----------------------------------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [4:0] aw_idx_q;
	logic aw_ok_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic bresp_err_q;
	logic wr_go;
	logic [4:0] aw_idx_in;
	logic aw_ok_in;
	logic wr_hit;

	assign aw_idx_in = S_AXI_AWADDR[6:2];
	assign aw_ok_in = (S_AXI_AWADDR[31:7] == 25'h0000000) && (S_AXI_AWADDR[1:0] == 2'h0);
	assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
	assign S_AXI_WREADY = ~w_have_q & ~bvalid_q;
	assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_err_q ? 2'h2 : 2'h0;

	// write address/data capture
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_idx_q <= 5'h00;
			aw_ok_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_q <= 1'b1;
				aw_idx_q <= aw_idx_in;
				aw_ok_q <= aw_ok_in;
			end else if (wr_go) begin
				aw_have_q <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_q <= 1'b1;
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			bvalid_q <= 1'b0;
			bresp_err_q <= 1'b0;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_err_q <= ~wr_hit;
		end else if (S_AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// write decode
	// -----------------------------------------------------------------
	function automatic logic is_idx(input logic ok, input logic [4:0] idx, input logic [4:0] r);
		is_idx = ok && (idx == r);
	endfunction : is_idx

	logic wr_adv;
	logic wr_crc;
	logic wr_ctrl;
	logic wr_iclr;
	logic wr_ien;
	logic [15:0] wd16;
	assign wd16 = wdata_q[15:0];
	assign wr_adv = wr_go & is_idx(aw_ok_q, aw_idx_q, IDX_ADV_CFG);
	assign wr_crc = wr_go & is_idx(aw_ok_q, aw_idx_q, IDX_CRCERR_CNT);
	assign wr_ctrl = wr_go & is_idx(aw_ok_q, aw_idx_q, IDX_CTRL);
	assign wr_iclr = wr_go & is_idx(aw_ok_q, aw_idx_q, IDX_IRQ_CLR);
	assign wr_ien = wr_go & is_idx(aw_ok_q, aw_idx_q, IDX_IRQ_EN);
	assign wr_hit = aw_ok_q && (aw_idx_q inside {IDX_ADV_CFG, IDX_LP_CFG, IDX_ALIGN_STAT,
		IDX_GOOD_CNT, IDX_CRCERR_CNT, IDX_CTRL, IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN});

	// -----------------------------------------------------------------
	// read channel: one cycle after address, held until rready
	// -----------------------------------------------------------------
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic rresp_err_q;
	logic rd_go;
	logic [4:0] ar_idx;
	logic ar_ok;
	logic rd_stat;
	logic rd_good;
	logic rd_crc;
	logic rd_hit;
	logic [15:0] rd_val;

	assign S_AXI_ARREADY = ~rvalid_q;
	assign rd_go = S_AXI_ARVALID & ~rvalid_q;
	assign ar_idx = S_AXI_ARADDR[6:2];
	assign ar_ok = (S_AXI_ARADDR[31:7] == 25'h0000000) && (S_AXI_ARADDR[1:0] == 2'h0);
	assign rd_stat = rd_go & is_idx(ar_ok, ar_idx, IDX_ALIGN_STAT);
	assign rd_good = rd_go & is_idx(ar_ok, ar_idx, IDX_GOOD_CNT);
	assign rd_crc = rd_go & is_idx(ar_ok, ar_idx, IDX_CRCERR_CNT);
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_err_q ? 2'h2 : 2'h0;

	// -----------------------------------------------------------------
	// control, advertised word, partner word
	// -----------------------------------------------------------------
	logic force_adv_q;
	logic [15:0] adv_q;
	logic [15:0] lp_q;
	logic [1:0] sel_q;

	// software registers
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			force_adv_q <= 1'b0;
			adv_q <= ADV_RESET;
			sel_q <= SEL_MEDIA;
		end else begin
			if (wr_ctrl && wstrb_q[0])
				force_adv_q <= wd16[CTRL_FORCE];
			if (wr_adv && force_adv_q && (&wstrb_q[1:0]))
				adv_q <= wd16;
			if (wr_crc && wstrb_q[1])
				sel_q <= wd16[SEL_LSB+:2];
		end
	end

	// partner word capture
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			lp_q <= 16'h0000;
		else if (PCS_EV.cfg_valid)
			lp_q <= PCS_EV.cfg_word;
	end

	// forced word replaces the automatic one
	assign ADV_WORD_OUT = force_adv_q ? adv_q : AUTO_ADV_WORD;
	// unforced protocol-transfer read shows the live word; not guaranteed
	logic [15:0] adv_rd;
	assign adv_rd = (PROTO_XFER_MODE && !force_adv_q) ? AUTO_ADV_WORD : adv_q;

	// -----------------------------------------------------------------
	// alignment status: sticky bits except live comma and position, set wins over read clear
	// -----------------------------------------------------------------
	logic realign_q;
	logic sigdet_q;
	logic fefi_q;
	logic comma_q;
	logic hls_q;
	logic [3:0] pos_q;
	logic [15:0] stat_val;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			realign_q <= 1'b0;
			sigdet_q <= 1'b0;
			fefi_q <= 1'b0;
			comma_q <= 1'b0;
			hls_q <= 1'b0;
			pos_q <= 4'h0;
		end else begin
			realign_q <= PCS_EV.realign | (realign_q & ~rd_stat);
			sigdet_q <= PCS_EV.sig_det | (sigdet_q & ~rd_stat);
			fefi_q <= PCS_EV.fefi | (fefi_q & ~rd_stat);
			comma_q <= rd_stat | PCS_EV.comma;
			hls_q <= PCS_EV.hls | (hls_q & ~rd_stat);
			if (PCS_EV.comma_pos <= 4'h9)
				pos_q <= PCS_EV.comma_pos;
		end
	end

	assign stat_val = {realign_q, sigdet_q, fefi_q, comma_q, pos_q, hls_q, 7'h00};

	// -----------------------------------------------------------------
	// receive counters, one set per source
	// -----------------------------------------------------------------
	logic [1:0] since_v;
	logic [13:0] good_v [2];
	logic [7:0] err_v [2];
	spasc_pkt_ev_t pkt_v [2];
	logic media_sel;
	logic mac_sel;
	assign pkt_v[0] = MEDIA_PKT;
	assign pkt_v[1] = MAC_PKT;
	assign media_sel = (sel_q == SEL_MEDIA);
	assign mac_sel = (sel_q == SEL_MAC);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cnt
			spasc_pkt_cnt u_cnt (
				.clk(CLK_SYS),
				.rst(RST),
				.link_up(MEDIA_LINK_UP),
				.ev(pkt_v[gi]),
				.good_clr(rd_good & (gi == 0 ? media_sel : mac_sel)),
				.err_clr(rd_crc & (gi == 0 ? media_sel : mac_sel)),
				.good_since(since_v[gi]),
				.good_cnt(good_v[gi]),
				.err_cnt(err_v[gi])
			);
		end
	endgenerate

	// counter view of the selected source, reserved select reads zero counts
	logic [15:0] good_val;
	logic [15:0] crc_val;
	assign good_val = media_sel ? {since_v[0], 1'b0, good_v[0]} :
		mac_sel ? {since_v[1], 1'b0, good_v[1]} : 16'h0000;
	assign crc_val = {sel_q, 6'h00, media_sel ? err_v[0] : mac_sel ? err_v[1] : 8'h00};

	// -----------------------------------------------------------------
	// interrupt: sticky event bits, write-one clear, enable mask
	// -----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [IRQ_W-1:0] irq_set;
	assign irq_set = {PCS_EV.hls, PCS_EV.fefi, PCS_EV.sig_det, PCS_EV.realign,
		(MEDIA_PKT.crc_err | MAC_PKT.crc_err) & MEDIA_LINK_UP};

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			irq_stat_q <= irq_set | (irq_stat_q & ~(wr_iclr ? wd16[IRQ_W-1:0] : '0));
			if (wr_ien)
				irq_en_q <= wd16[IRQ_W-1:0];
		end
	end

	assign IRQ = |(irq_stat_q & irq_en_q);

	// -----------------------------------------------------------------
	// read mux and response
	// -----------------------------------------------------------------
	always_comb begin
		rd_val = 16'h0000;
		rd_hit = ar_ok;
		case (ar_idx)
			IDX_ADV_CFG: rd_val = adv_rd;
			IDX_LP_CFG: rd_val = lp_q;
			IDX_ALIGN_STAT: rd_val = stat_val;
			IDX_GOOD_CNT: rd_val = good_val;
			IDX_CRCERR_CNT: rd_val = crc_val;
			IDX_CTRL: rd_val = {15'h0000, force_adv_q};
			IDX_IRQ_STAT: rd_val = {11'h000, irq_stat_q};
			IDX_IRQ_EN: rd_val = {11'h000, irq_en_q};
			IDX_IRQ_CLR: rd_val = 16'h0000;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_err_q <= 1'b0;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0000, rd_val};
			rresp_err_q <= ~rd_hit;
		end else if (S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	chk_adv_locked: assert property (@(posedge CLK_SYS) disable iff (RST)
		!force_adv_q |=> adv_q == $past(adv_q)) else $error("advertised word changed unforced");
	chk_adv_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
		force_adv_q |-> ADV_WORD_OUT == adv_q) else $error("forced word not advertised");
	chk_lp_capture: assert property (@(posedge CLK_SYS) disable iff (RST)
		PCS_EV.cfg_valid |=> lp_q == $past(PCS_EV.cfg_word)) else $error("partner word lost");
	chk_realign_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
		realign_q && !rd_stat |=> realign_q) else $error("realign bit dropped unread");
	chk_sigdet_set: assert property (@(posedge CLK_SYS) disable iff (RST)
		PCS_EV.sig_det |=> sigdet_q) else $error("signal detect not latched");
	chk_fefi_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
		rd_stat && !PCS_EV.fefi |=> !fefi_q) else $error("fault bit not cleared by read");
	chk_comma_read: assert property (@(posedge CLK_SYS) disable iff (RST)
		rd_stat |=> comma_q) else $error("comma bit not set by read");
	chk_pos_range: assert property (@(posedge CLK_SYS) disable iff (RST)
		pos_q <= 4'h9) else $error("comma position out of range");
	chk_hls_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
		PCS_EV.hls ##1 !rd_stat |=> hls_q) else $error("halt line bit lost");
	chk_rd_answer: assert property (@(posedge CLK_SYS) disable iff (RST)
		rd_go |=> S_AXI_RVALID) else $error("read not answered next cycle");
	cov_force_write: cover property (@(posedge CLK_SYS) disable iff (RST) wr_adv && force_adv_q);
	cov_stat_read: cover property (@(posedge CLK_SYS) disable iff (RST) rd_stat && realign_q);
	cov_mac_good: cover property (@(posedge CLK_SYS) disable iff (RST) rd_good && mac_sel);
	cov_irq: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(IRQ));

endmodule : spasc_regs

// ---- test/spasc_link_model.sv ----
// far-side model: pcs line events and received packet pulses
// assumes the bench calls its tasks; every change follows a rising edge
module spasc_link_model
	import spasc_pkg::*;
(
	// clock
	input wire logic clk,
	// far-side events
	output spasc_pcs_ev_t pcs_ev,
	output spasc_pkt_ev_t media_pkt,
	output spasc_pkt_ev_t mac_pkt
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle line at time zero
	initial begin
		pcs_ev = '0;
		media_pkt = '0;
		mac_pkt = '0;
	end

	// one pulse per packet, back to back
	task automatic send_pkts(input logic mac, input logic good, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			if (mac) mac_pkt <= {good, !good};
			else media_pkt <= {good, !good};
		end
		@(posedge clk);
		media_pkt <= '0;
		mac_pkt <= '0;
	endtask : send_pkts

	// one-cycle events; comma level and position stay
	task automatic pulse(input spasc_pcs_ev_t ev);
		@(posedge clk);
		pcs_ev <= ev;
		@(posedge clk);
		ev.realign = 1'b0;
		ev.sig_det = 1'b0;
		ev.fefi = 1'b0;
		ev.hls = 1'b0;
		ev.cfg_valid = 1'b0;
		ev.cfg_word = ~ev.cfg_word; // word no longer qualified
		pcs_ev <= ev;
	endtask : pulse
endmodule : spasc_link_model

// ---- test/tb_serdes_pcs_ability_status_counters.sv ----
// bench for the serdes pcs register bank
// assumes the far-side model drives all pcs and packet events
module tb_serdes_pcs_ability_status_counters
	import spasc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic CLK_SYS, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
	logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, IRQ;
	logic PROTO_XFER_MODE, MEDIA_LINK_UP;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	logic [15:0] AUTO_ADV_WORD, ADV_WORD_OUT;
	logic [31:0] d;
	spasc_pcs_ev_t PCS_EV, ev;
	spasc_pkt_ev_t MEDIA_PKT, MAC_PKT;
	int failures = 0;
	int total_checks = 0;

	spasc_regs spasc_regs_inst (.CLK_SYS(CLK_SYS), .RST(RST),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .PCS_EV(PCS_EV),
		.AUTO_ADV_WORD(AUTO_ADV_WORD), .PROTO_XFER_MODE(PROTO_XFER_MODE),
		.MEDIA_LINK_UP(MEDIA_LINK_UP), .MEDIA_PKT(MEDIA_PKT), .MAC_PKT(MAC_PKT),
		.ADV_WORD_OUT(ADV_WORD_OUT), .IRQ(IRQ));

	spasc_link_model spasc_link_model_inst (.clk(CLK_SYS), .pcs_ev(PCS_EV),
		.media_pkt(MEDIA_PKT), .mac_pkt(MAC_PKT));

	// 50 ns clock
	always #25 CLK_SYS = ~CLK_SYS;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one axi4-lite write, both halves offered together
	task automatic wr(input logic [4:0] idx, input logic [15:0] v, output logic [1:0] resp);
		int n;
		@(posedge CLK_SYS);
		S_AXI_AWADDR <= {25'h0, idx, 2'h0};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA <= {16'h0, v};
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge CLK_SYS);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
			if (S_AXI_BVALID) break;
		end
		resp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
		if (n == 100) begin
			failures++;
			close_out();
		end
	endtask : wr

	// one axi4-lite read
	task automatic rd(input logic [4:0] idx, output logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge CLK_SYS);
		S_AXI_ARADDR <= {25'h0, idx, 2'h0};
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge CLK_SYS);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_RVALID) break;
		end
		v = S_AXI_RDATA;
		resp = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
		if (n == 100) begin
			failures++;
			close_out();
		end
	endtask : rd

	task automatic rdc(input logic [4:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] rr;
		rd(idx, v, rr);
		chk(v, exp);
	endtask : rdc

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{CLK_SYS, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
		{S_AXI_ARVALID, S_AXI_RREADY, PROTO_XFER_MODE, MEDIA_LINK_UP} = '0;
		{S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = '0;
		S_AXI_WSTRB = 4'hF;
		AUTO_ADV_WORD = 16'hA5C3;
		RST = 1'b1;
		repeat (8) @(posedge CLK_SYS);
		RST <= 1'b0;
		// advertised word locked until forced
		rdc(IDX_ADV_CFG, 32'h0);
		wr(IDX_ADV_CFG, 16'h1234, r);
		rdc(IDX_ADV_CFG, 32'h0);
		chk({16'h0, ADV_WORD_OUT}, 32'hA5C3);
		wr(IDX_CTRL, 16'h0001, r);
		wr(IDX_ADV_CFG, 16'h1234, r);
		rdc(IDX_ADV_CFG, 32'h1234);
		chk({16'h0, ADV_WORD_OUT}, 32'h1234);
		// forced word still reads back in protocol transfer mode
		PROTO_XFER_MODE <= 1'b1;
		rdc(IDX_ADV_CFG, 32'h1234);
		PROTO_XFER_MODE <= 1'b0;
		// every status event, position at top value
		ev = '0;
		{ev.realign, ev.sig_det, ev.fefi, ev.hls, ev.comma, ev.cfg_valid} = '1;
		ev.comma_pos = 4'h9;
		ev.cfg_word = 16'hBEEF;
		spasc_link_model_inst.pulse(ev);
		rdc(IDX_LP_CFG, 32'hBEEF);
		rdc(IDX_ALIGN_STAT, 32'hF980);
		spasc_link_model_inst.pulse('0);
		rdc(IDX_ALIGN_STAT, 32'h0);
		// interrupt: raise, clear, mask
		wr(IDX_IRQ_EN, 16'h0002, r);
		rdc(IDX_IRQ_STAT, 32'h1E);
		chk({31'h0, IRQ}, 32'h1);
		wr(IDX_IRQ_CLR, 16'h001E, r);
		chk({31'h0, IRQ}, 32'h0);
		wr(IDX_IRQ_EN, 16'h0000, r);
		ev = '0;
		ev.realign = 1'b1;
		spasc_link_model_inst.pulse(ev);
		@(negedge CLK_SYS);
		chk({31'h0, IRQ}, 32'h0);
		wr(IDX_IRQ_EN, 16'h0002, r);
		chk({31'h0, IRQ}, 32'h1);
		wr(IDX_IRQ_CLR, 16'h0002, r);
		// unmapped place
		rd(5'h00, d, r);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		wr(5'h01, 16'hFFFF, r);
		chk({30'h0, r}, 32'h2);
		// counters frozen while link down
		spasc_link_model_inst.send_pkts(1'b0, 1'b1, 3);
		spasc_link_model_inst.send_pkts(1'b1, 1'b1, 2);
		rdc(IDX_GOOD_CNT, 32'h0);
		MEDIA_LINK_UP <= 1'b1;
		spasc_link_model_inst.send_pkts(1'b0, 1'b1, 3);
		spasc_link_model_inst.send_pkts(1'b0, 1'b0, 2);
		spasc_link_model_inst.send_pkts(1'b1, 1'b1, 5);
		rdc(IDX_GOOD_CNT, 32'h8003);
		rdc(IDX_GOOD_CNT, 32'h0);
		rdc(IDX_CRCERR_CNT, 32'h2);
		// mac source, then reserved select leaves counts alone
		wr(IDX_CRCERR_CNT, 16'h4000, r);
		rdc(IDX_CRCERR_CNT, 32'h4000);
		wr(IDX_CRCERR_CNT, 16'h8000, r);
		rdc(IDX_GOOD_CNT, 32'h0);
		wr(IDX_CRCERR_CNT, 16'h4000, r);
		rdc(IDX_GOOD_CNT, 32'h8005);
		wr(IDX_CRCERR_CNT, 16'h0000, r);
		// error count saturates, clears, resumes
		spasc_link_model_inst.send_pkts(1'b0, 1'b0, 300);
		rdc(IDX_CRCERR_CNT, 32'hFF);
		spasc_link_model_inst.send_pkts(1'b0, 1'b0, 1);
		rdc(IDX_CRCERR_CNT, 32'h1);
		// good count rolls over at ten thousand
		spasc_link_model_inst.send_pkts(1'b0, 1'b1, 10001);
		rdc(IDX_GOOD_CNT, 32'h8001);
		// packet on the clearing edge survives
		fork
			rd(IDX_GOOD_CNT, d, r);
			spasc_link_model_inst.send_pkts(1'b0, 1'b1, 1);
		join
		chk(d, 32'h0);
		rdc(IDX_GOOD_CNT, 32'h8001);
		close_out();
	end
endmodule : tb_serdes_pcs_ability_status_counters
